// ### rtl/lpr_pkg.sv
// lpr_pkg: register indices, field positions, reset values, command codes and timing counts
// for the low-rate receive control block; assumes a 200 MHz system clock.
// Function
// - preamble first, then timing, then delimiter
// - four clocks and four bits per symbol
// - serial mode stays receiving, no frame event
// - programmable delimiter used for receive
// - op select 0 packet, 2 serial output
// - strip delimiter, store length and bytes
// - checksum off: store checksum, always signal
// - checksum on: signal on match, store quality
// - each frame stored from base address
// - buffer mode 0 returns ready after frame
// - buffer mode 1 rearms after delay
// - buffer mode 2 blocks frames, assessment runs
// - receive command calibrates, oscillator step skippable
// - receive after basic plus extension delay
// - auto assessment on entering receive
// - delimiter found raises delimiter event
// - clear flag when average below threshold
// - single assessment ends in ready state
// - continuous assessment repeats until ready command
// - readback holds, updates just before completion
// - averaging field selects window, software programs 2
// - quality stored in second checksum byte
package lpr_pkg;
	// word indices; byte address is four times the index
	localparam logic [9:0] IX_THR = 10'h105, IX_ASSESS = 10'h106, IX_BUFCFG = 10'h107;
	localparam logic [9:0] IX_PKTCFG = 10'h108, IX_DLY0 = 10'h109, IX_DLY2 = 10'h10b;
	localparam logic [9:0] IX_OPMODE = 10'h13e, IX_BASE = 10'h315, IX_OSC = 10'h36f;
	localparam logic [9:0] IX_AVG = 10'h3b9, IX_DELIM = 10'h3f4;
	localparam logic [9:0] IX_CMD = 10'h3e0, IX_STATUS = 10'h3e1, IX_RSSI = 10'h3e2;
	localparam logic [9:0] IX_MEM_TOP = 10'h0ff;
	// field positions and values
	localparam int AUTO_ASSESS_BIT = 1;
	localparam int CONT_ASSESS_BIT = 2;
	localparam int FCS_OFF_BIT = 0;
	localparam int STAT_CLEAR_BIT = 7;
	localparam logic [7:0] OP_PACKET = 8'h00, OP_SERIAL = 8'h02;
	localparam logic [1:0] BUFM_READY = 2'h0, BUFM_STAY = 2'h1, BUFM_OFF = 2'h2;
	localparam logic [3:0] OSC_SKIP = 4'hf;
	localparam logic [7:0] DELIM_RST = 8'ha7;
	localparam logic [7:0] REG_RST = 8'h00;
	// command codes written to the command register
	localparam logic [7:0] CMD_GO_READY = 8'h03, CMD_RECEIVE = 8'h04, CMD_ASSESS = 8'h05;
	// checksum generator x^16+x^12+x^5+1, bit-reversed for lsb-first shifting
	localparam logic [15:0] CRC_POLY_REV = 16'h8408;
	// timing
	localparam int CLK_NS = 5;
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = US_NS / CLK_NS;
	localparam int EXT_STEP_US = 4;
	localparam int WIN_BASE_US = 16;
	localparam int WIN_BASE_SHIFT = 4;
	localparam int CAL_SYNTH_US = 2;
	localparam int CAL_OFFSET_US = 2;
	localparam int CAL_OSC_US = 2;
endpackage

// ### rtl/lpr_nib_if.sv
// lpr_nib_if: nibble stream from the receive sequencer to the checksum and serial units
// assumes all parties run on one clock
`timescale 1ns/1ps
`default_nettype none
interface lpr_nib_if;
	logic       clr;
	logic [3:0] nib;
	logic       crcStb;
	logic       serStb;
	logic       crcOk;
	modport ctl (output clr, output nib, output crcStb, output serStb, input crcOk);
	modport crc (input clr, input nib, input crcStb, output crcOk);
	modport ser (input nib, input serStb);
endinterface
`default_nettype wire

// ### rtl/lpr_crc16.sv
// lpr_crc16: running frame checksum over received nibbles, lsb first
// assumes the checksum field itself is fed too, so a good frame leaves zero
`timescale 1ns/1ps
`default_nettype none
module lpr_crc16 (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic clkEn,
	lpr_nib_if.crc    nibIf
);
	logic [15:0] crc_r;

	// four serial steps of the reflected generator
	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [3:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ lpr_pkg::CRC_POLY_REV) : (r >> 1);
		end
		return r;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			crc_r <= 16'h0000;
		end else if (clkEn) begin
			if (nibIf.clr) begin
				crc_r <= 16'h0000;
			end else if (nibIf.crcStb) begin
				crc_r <= crcStep(crc_r, nibIf.nib);
			end
		end
	end

	assign nibIf.crcOk = (crc_r == 16'h0000);
endmodule
`default_nettype wire

// ### rtl/lpr_serial_out.sv
// lpr_serial_out: shifts each received symbol out as four clocked data bits
// assumes symbols arrive at least nine cycles apart
`timescale 1ns/1ps
`default_nettype none
module lpr_serial_out (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic clkEn,
	lpr_nib_if.ser    nibIf,
	output logic      serialClockPin,
	output logic      serialDataPin
);
	logic [3:0] shf_r;
	logic [2:0] left_r;
	logic [2:0] pulseCnt_r;

	// four pulses per symbol
	// data changes on the low phase so the host samples on the rising edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shf_r          <= 4'h0;
			left_r         <= 3'h0;
			serialClockPin <= 1'b0;
			serialDataPin  <= 1'b0;
		end else if (clkEn) begin
			if (nibIf.serStb) begin
				shf_r          <= nibIf.nib;
				left_r         <= 3'h4;
				serialClockPin <= 1'b0;
				serialDataPin  <= nibIf.nib[0];
			end else if (left_r != 3'h0) begin
				if (!serialClockPin) begin
					serialClockPin <= 1'b1;
				end else begin
					serialClockPin <= 1'b0;
					left_r         <= left_r - 3'h1;
					shf_r          <= shf_r >> 1;
					serialDataPin  <= shf_r[1];
				end
			end
		end
	end

	// pulse count for checking only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pulseCnt_r <= 3'h0;
		end else if (clkEn) begin
			if (nibIf.serStb) begin
				pulseCnt_r <= 3'h0;
			end else if (left_r != 3'h0 && !serialClockPin) begin
				pulseCnt_r <= pulseCnt_r + 3'h1;
			end
		end
	end

	property p_four_pulses;
		@(posedge sys_clk) disable iff (rst || !clkEn)
		(left_r == 3'h1 && serialClockPin && !nibIf.serStb) |=> (pulseCnt_r == 3'h4 && left_r == 3'h0);
	endproperty
	a_four_pulses: assert property (p_four_pulses) else $error("symbol did not give four clock pulses");
endmodule
`default_nettype wire

// ### rtl/lpr_rx_ctrl.sv
// lpr_rx_ctrl: receive sequencer, frame store, channel assessment and register file
// assumes demodulated symbols and correlator status synchronous to sys_clk,
// and an Avalon-MM master that holds its request until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module lpr_rx_ctrl (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        preambleOk,
	input  wire logic        symValid,
	input  wire logic [3:0]  symData,
	input  wire logic [7:0]  rssiIn,
	input  wire logic [7:0]  sqiIn,
	output logic             serialClockPin,
	output logic             serialDataPin,
	output logic             delimIrq,
	output logic             frameRcvdIrq,
	output logic             assessDoneIrq,
	output logic             channelClear,
	output logic [3:0]       radioState
);
	typedef enum logic [3:0] {
		ST_READY, ST_CAL, ST_DLY, ST_HUNT, ST_SYNC, ST_DATA, ST_FIN, ST_SERIAL, ST_ASSESS
	} lpr_state_t;

	lpr_state_t state;
	lpr_nib_if  nibIf ();

	// =====================================================
	// register bus slave
	logic [9:0]  regIx;
	logic        busTake;
	logic        wrEn;
	logic [7:0]  thr_r;
	logic [7:0]  assessCfg_r;
	logic [7:0]  bufCfg_r;
	logic [7:0]  pktCfg_r;
	logic [7:0]  dly0_r;
	logic [7:0]  dly2_r;
	logic [7:0]  opMode_r;
	logic [7:0]  base_r;
	logic [7:0]  oscCfg_r;
	logic [7:0]  avgCfg_r;
	logic [7:0]  delim_r;
	logic [7:0]  rssiRb_r;
	logic [7:0]  rxMem [0:255];

	assign regIx   = avs_address[11:2];
	assign busTake = (avs_read | avs_write) & avs_waitrequest;
	assign wrEn    = avs_write & ~avs_waitrequest;

	// command decode shared by the three commands
	function automatic logic cmdHit(input logic we, input logic [9:0] ix, input logic [7:0] d,
			input logic [7:0] code);
		return we && ix == lpr_pkg::IX_CMD && d == code;
	endfunction

	logic goReadyCmd;
	logic receiveCmd;
	logic assessCmd;
	logic anyCmd;
	assign goReadyCmd = cmdHit(wrEn, regIx, avs_writedata[7:0], lpr_pkg::CMD_GO_READY);
	assign receiveCmd = cmdHit(wrEn, regIx, avs_writedata[7:0], lpr_pkg::CMD_RECEIVE);
	assign assessCmd  = cmdHit(wrEn, regIx, avs_writedata[7:0], lpr_pkg::CMD_ASSESS);
	assign anyCmd     = goReadyCmd | receiveCmd | assessCmd;

	// one wait cycle: waitrequest drops for exactly the accepting edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if (clkEn) begin
			avs_waitrequest <= ~busTake;
		end
	end

	// read data is prepared in the wait cycle so it stands at the accepting edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (clkEn && busTake && avs_read) begin
			avs_readdata <= 32'h0000_0000;
			if (regIx <= lpr_pkg::IX_MEM_TOP) begin
				avs_readdata[7:0] <= rxMem[regIx[7:0]];
			end else begin
				case (regIx)
					lpr_pkg::IX_THR:    avs_readdata[7:0] <= thr_r;
					lpr_pkg::IX_ASSESS: avs_readdata[7:0] <= assessCfg_r;
					lpr_pkg::IX_BUFCFG: avs_readdata[7:0] <= bufCfg_r;
					lpr_pkg::IX_PKTCFG: avs_readdata[7:0] <= pktCfg_r;
					lpr_pkg::IX_DLY0:   avs_readdata[7:0] <= dly0_r;
					lpr_pkg::IX_DLY2:   avs_readdata[7:0] <= dly2_r;
					lpr_pkg::IX_OPMODE: avs_readdata[7:0] <= opMode_r;
					lpr_pkg::IX_BASE:   avs_readdata[7:0] <= base_r;
					lpr_pkg::IX_OSC:    avs_readdata[7:0] <= oscCfg_r;
					lpr_pkg::IX_AVG:    avs_readdata[7:0] <= avgCfg_r;
					lpr_pkg::IX_DELIM:  avs_readdata[7:0] <= delim_r;
					lpr_pkg::IX_STATUS: avs_readdata[7:0] <= {channelClear, 3'h0, state};
					lpr_pkg::IX_RSSI:   avs_readdata[7:0] <= rssiRb_r;
					default:            avs_readdata[7:0] <= 8'h00;
				endcase
			end
		end
	end

	// configuration registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			thr_r       <= lpr_pkg::REG_RST;
			assessCfg_r <= lpr_pkg::REG_RST;
			bufCfg_r    <= lpr_pkg::REG_RST;
			pktCfg_r    <= lpr_pkg::REG_RST;
			dly0_r      <= lpr_pkg::REG_RST;
			dly2_r      <= lpr_pkg::REG_RST;
			opMode_r    <= lpr_pkg::REG_RST;
			base_r      <= lpr_pkg::REG_RST;
			oscCfg_r    <= lpr_pkg::REG_RST;
			avgCfg_r    <= lpr_pkg::REG_RST;
			delim_r     <= lpr_pkg::DELIM_RST;
		end else if (clkEn && wrEn) begin
			case (regIx)
				lpr_pkg::IX_THR:    thr_r       <= avs_writedata[7:0];
				lpr_pkg::IX_ASSESS: assessCfg_r <= avs_writedata[7:0];
				lpr_pkg::IX_BUFCFG: bufCfg_r    <= avs_writedata[7:0];
				lpr_pkg::IX_PKTCFG: pktCfg_r    <= avs_writedata[7:0];
				lpr_pkg::IX_DLY0:   dly0_r      <= avs_writedata[7:0];
				lpr_pkg::IX_DLY2:   dly2_r      <= avs_writedata[7:0];
				lpr_pkg::IX_OPMODE: opMode_r    <= avs_writedata[7:0];
				lpr_pkg::IX_BASE:   base_r      <= avs_writedata[7:0];
				lpr_pkg::IX_OSC:    oscCfg_r    <= avs_writedata[7:0];
				lpr_pkg::IX_AVG:    avgCfg_r    <= avs_writedata[7:0];
				lpr_pkg::IX_DELIM:  delim_r     <= avs_writedata[7:0];
				default: ;
			endcase
		end
	end

	// =====================================================
	// microsecond tick and derived delays
	logic [7:0]  usCnt_r;
	logic        usTick;
	logic [10:0] macUs;
	logic [3:0]  calUs;
	logic        serialMode;
	logic [1:0]  bufMode;
	logic        fcsOff;

	assign usTick     = (usCnt_r == 8'(lpr_pkg::CYC_PER_US - 1));
	assign macUs      = {3'h0, dly0_r} + 11'({dly2_r, 2'h0});
	// oscillator step skipped only at the skip value
	assign calUs      = 4'(lpr_pkg::CAL_SYNTH_US + lpr_pkg::CAL_OFFSET_US)
		+ ((oscCfg_r[3:0] == lpr_pkg::OSC_SKIP) ? 4'h0 : 4'(lpr_pkg::CAL_OSC_US));
	assign serialMode = (opMode_r == lpr_pkg::OP_SERIAL);
	assign bufMode    = bufCfg_r[1:0];
	assign fcsOff     = pktCfg_r[lpr_pkg::FCS_OFF_BIT];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			usCnt_r <= 8'h00;
		end else if (clkEn) begin
			usCnt_r <= usTick ? 8'h00 : usCnt_r + 8'h01;
		end
	end

	// =====================================================
	// receive sequencer
	logic [10:0] waitUs_r;
	logic        assessOnly_r;
	logic        autoArm_r;
	logic [3:0]  prevSym_r;
	logic [3:0]  lowNib_r;
	logic        half_r;
	logic [7:0]  idx_r;
	logic [6:0]  len_r;
	logic        delimHit;
	logic        byteDone;
	logic [7:0]  byteVal;
	logic        lastByte;
	logic        assessStart;
	logic        assessFin_r;

	assign delimHit = symValid && ({symData, prevSym_r} == delim_r);
	assign byteDone = (state == ST_DATA) && symValid && half_r;
	assign byteVal  = {symData, lowNib_r};
	assign lastByte = (idx_r == 8'h00) ? (byteVal[6:0] == 7'h00) : (idx_r == {1'b0, len_r});
	assign assessStart = (state == ST_DLY) && (waitUs_r == 11'h000) && !anyCmd
		&& (assessOnly_r || (autoArm_r && assessCfg_r[lpr_pkg::AUTO_ASSESS_BIT]));

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prevSym_r <= 4'h0;
		end else if (clkEn && symValid) begin
			prevSym_r <= symData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state        <= ST_READY;
			waitUs_r     <= 11'h000;
			assessOnly_r <= 1'b0;
			autoArm_r    <= 1'b0;
			half_r       <= 1'b0;
			lowNib_r     <= 4'h0;
			idx_r        <= 8'h00;
			len_r        <= 7'h00;
			delimIrq     <= 1'b0;
			frameRcvdIrq <= 1'b0;
		end else if (clkEn) begin
			delimIrq     <= 1'b0;
			frameRcvdIrq <= 1'b0;
			if (goReadyCmd) begin
				state <= ST_READY;
			end else if (receiveCmd) begin
				state        <= ST_CAL;
				waitUs_r     <= {7'h00, calUs};
				assessOnly_r <= 1'b0;
				autoArm_r    <= 1'b1;
			end else if (assessCmd) begin
				state        <= ST_DLY;
				waitUs_r     <= macUs;
				assessOnly_r <= 1'b1;
			end else begin
				case (state)
					ST_CAL: begin
						if (waitUs_r == 11'h000) begin
							state    <= ST_DLY;
							waitUs_r <= macUs;
						end else if (usTick) begin
							waitUs_r <= waitUs_r - 11'h001;
						end
					end
					ST_DLY: begin
						if (waitUs_r == 11'h000) begin
							state     <= assessOnly_r ? ST_ASSESS : ST_HUNT;
							autoArm_r <= 1'b0;
						end else if (usTick) begin
							waitUs_r <= waitUs_r - 11'h001;
						end
					end
					// frames blocked in buffer mode 2
					ST_HUNT: begin
						if (preambleOk && (serialMode || bufMode != lpr_pkg::BUFM_OFF)) begin
							state <= ST_SYNC;
						end
					end
					ST_SYNC: begin
						if (!preambleOk) begin
							state <= ST_HUNT;
						end else if (delimHit) begin
							delimIrq <= 1'b1;
							state    <= serialMode ? ST_SERIAL : ST_DATA;
							half_r   <= 1'b0;
							idx_r    <= 8'h00;
						end
					end
					ST_DATA: begin
						if (symValid) begin
							half_r   <= ~half_r;
							lowNib_r <= symData;
							if (half_r) begin
								idx_r <= idx_r + 8'h01;
								if (idx_r == 8'h00) begin
									len_r <= byteVal[6:0];
								end
								if (lastByte) begin
									state <= ST_FIN;
								end
							end
						end
					end
					// checksum on signals only on match
					ST_FIN: begin
						if (fcsOff || nibIf.crcOk) begin
							frameRcvdIrq <= 1'b1;
							if (bufMode == lpr_pkg::BUFM_STAY) begin
								state    <= ST_DLY;
								waitUs_r <= macUs;
							end else begin
								state <= ST_READY;
							end
						end else begin
							state <= ST_HUNT;
						end
					end
					// serial mode leaves only on command
					ST_SERIAL: state <= ST_SERIAL;
					ST_ASSESS: begin
						if (assessFin_r && !assessCfg_r[lpr_pkg::CONT_ASSESS_BIT]) begin
							state <= ST_READY;
						end
					end
					default: state <= ST_READY;
				endcase
			end
		end
	end

	assign radioState = state;

	// frame store; memory has no reset, contents survive between frames
	logic [7:0] memData;
	always_comb begin
		memData = byteVal;
		if (!fcsOff && idx_r != 8'h00 && len_r >= 7'h02) begin
			if (idx_r == {1'b0, len_r} - 8'h01) begin
				memData = rssiIn;
			end else if (idx_r == {1'b0, len_r}) begin
				memData = sqiIn;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clkEn && byteDone && !goReadyCmd && !receiveCmd && !assessCmd) begin
			rxMem[base_r + idx_r] <= memData;
		end
	end

	// nibble stream; length byte is outside the checksum
	assign nibIf.clr    = (state == ST_SYNC) && delimHit;
	assign nibIf.nib    = symData;
	assign nibIf.crcStb = (state == ST_DATA) && symValid && (idx_r != 8'h00);
	assign nibIf.serStb = (state == ST_SERIAL) && symValid;

	lpr_crc16 uCrc (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clkEn   (clkEn),
		.nibIf   (nibIf.crc)
	);

	lpr_serial_out uSer (
		.sys_clk        (sys_clk),
		.rst            (rst),
		.clkEn          (clkEn),
		.nibIf          (nibIf.ser),
		.serialClockPin (serialClockPin),
		.serialDataPin  (serialDataPin)
	);

	// =====================================================
	// channel assessment: one rssi sample per microsecond
	logic        assessRun_r;
	logic [7:0]  sampCnt_r;
	logic [15:0] sum_r;
	logic [15:0] sumNxt;
	logic [7:0]  winUs;
	logic [7:0]  avgNxt;
	logic        winEnd;

	// window 16 us doubled per step
	assign winUs  = 8'(lpr_pkg::WIN_BASE_US) << avgCfg_r[1:0];
	assign sumNxt = sum_r + {8'h00, rssiIn};
	assign avgNxt = 8'(sumNxt >> (lpr_pkg::WIN_BASE_SHIFT + int'(avgCfg_r[1:0])));
	assign winEnd = assessRun_r && usTick && (sampCnt_r == winUs - 8'h01);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			assessRun_r   <= 1'b0;
			sampCnt_r     <= 8'h00;
			sum_r         <= 16'h0000;
			rssiRb_r      <= 8'h00;
			channelClear  <= 1'b0;
			assessFin_r   <= 1'b0;
			assessDoneIrq <= 1'b0;
		end else if (clkEn) begin
			assessFin_r   <= winEnd && !anyCmd;
			assessDoneIrq <= assessFin_r;
			if (anyCmd) begin
				assessRun_r <= 1'b0;
			end else if (assessStart) begin
				assessRun_r <= 1'b1;
				sampCnt_r   <= 8'h00;
				sum_r       <= 16'h0000;
			end else if (winEnd) begin
				// readback moves one cycle before completion
				rssiRb_r     <= avgNxt;
				channelClear <= (avgNxt < thr_r);
				assessRun_r  <= (state == ST_ASSESS) && assessCfg_r[lpr_pkg::CONT_ASSESS_BIT];
				sampCnt_r    <= 8'h00;
				sum_r        <= 16'h0000;
			end else if (assessRun_r && usTick) begin
				sampCnt_r <= sampCnt_r + 8'h01;
				sum_r     <= sumNxt;
			end
		end
	end

	// =====================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst || !clkEn);

	property p_delim_irq;
		(state == ST_SYNC && preambleOk && delimHit && !anyCmd) |=> delimIrq;
	endproperty
	a_delim_irq: assert property (p_delim_irq) else $error("delimiter event missing");

	property p_serial_stay;
		(state == ST_SERIAL && !anyCmd) |=> (state == ST_SERIAL && !frameRcvdIrq);
	endproperty
	a_serial_stay: assert property (p_serial_stay) else $error("serial mode left receive");

	property p_ready_after;
		(state == ST_FIN && !anyCmd && (fcsOff || nibIf.crcOk) && bufMode == lpr_pkg::BUFM_READY)
			|=> (state == ST_READY && frameRcvdIrq);
	endproperty
	a_ready_after: assert property (p_ready_after) else $error("no ready after frame");

	property p_bad_crc;
		(state == ST_FIN && !anyCmd && !fcsOff && !nibIf.crcOk) |=> (!frameRcvdIrq && state == ST_HUNT);
	endproperty
	a_bad_crc: assert property (p_bad_crc) else $error("bad checksum signalled");

	property p_stay_rearm;
		(state == ST_FIN && !anyCmd && fcsOff && bufMode == lpr_pkg::BUFM_STAY)
			|=> (state == ST_DLY && waitUs_r == $past(macUs));
	endproperty
	a_stay_rearm: assert property (p_stay_rearm) else $error("no rearm delay");

	property p_no_frames;
		(state == ST_HUNT && bufMode == lpr_pkg::BUFM_OFF && !serialMode && !anyCmd) |=> state == ST_HUNT;
	endproperty
	a_no_frames: assert property (p_no_frames) else $error("frame accepted while blocked");

	property p_rssi_hold;
		!$stable(rssiRb_r) |=> assessDoneIrq;
	endproperty
	a_rssi_hold: assert property (p_rssi_hold) else $error("readback moved mid window");

	property p_assess_end;
		(assessFin_r && state == ST_ASSESS && !assessCfg_r[lpr_pkg::CONT_ASSESS_BIT] && !anyCmd)
			|=> (state == ST_READY && assessDoneIrq);
	endproperty
	a_assess_end: assert property (p_assess_end) else $error("single assessment did not end");

	property p_abort;
		goReadyCmd |=> (state == ST_READY) ##1 !frameRcvdIrq;
	endproperty
	a_abort: assert property (p_abort) else $error("ready command not obeyed");

	property p_cal;
		receiveCmd |=> (state == ST_CAL && waitUs_r == {7'h00, $past(calUs)});
	endproperty
	a_cal: assert property (p_cal) else $error("receive did not calibrate");
endmodule
`default_nettype wire

// ### tb/lpr_sym_src.sv
// lpr_sym_src: demodulator stand-in, sends one byte as two symbols, low nibble first
// assumes go is a level held until busy rises; symbols stay at least ten cycles apart
`timescale 1ns/1ps
`default_nettype none
module lpr_sym_src (
	input  wire logic       sys_clk,
	input  wire logic       go,
	input  wire logic [7:0] byteIn,
	output logic            busy,
	output logic            symValid,
	output logic [3:0]      symData
);
	logic [4:0] cnt;
	logic [7:0] b;
	initial begin
		busy = 0; symValid = 0; symData = 0; cnt = 0; b = 0;
	end
	// symbol data toggles between pulses so a stale nibble is never mistaken for a fresh one
	always @(posedge sys_clk) begin
		symValid <= 0;
		symData  <= ~symData;
		if (go && !busy) begin
			busy <= 1; b <= byteIn; cnt <= 0;
		end else if (busy) begin
			cnt <= cnt + 5'h01;
			if (cnt == 5'h01 || cnt == 5'h0b) begin
				symValid <= 1;
				symData  <= (cnt == 5'h01) ? b[3:0] : b[7:4];
			end
			if (cnt == 5'h15) busy <= 0;
		end
	end
endmodule
`default_nettype wire

// ### tb/lpr_rx_ctrl_tb_top.sv
// lpr_rx_ctrl_tb_top: self-checking bench, register bus, receive, serial and assessment
// assumes one clock; the bus task waits for waitrequest low however long that takes
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin nChecks++; if ((g)!==(e)) begin mismatches++; $display("Error %s exp %h got %h",n,e,g); end end
module lpr_rx_ctrl_tb_top;
	logic sys_clk = 0, rst = 1, rd_r, wr_r, pre = 0, go = 0, busy, sv, sck, sdat, dI, fI, aI, clr;
	logic [11:0] adr = 0;
	logic [31:0] wd = 0, rdat;
	logic [7:0] rssi = 0, sqi = 8'h5a, byteIn = 0, rd, d[3], sb = 0, sBits = 0;
	logic [3:0] sd, st;
	logic wq, sawD = 0, sawF = 0, sawA = 0, pClk = 0, clrF = 0, en = 1;
	int mismatches = 0, nChecks = 0, seed = 32'h24d5, nClk = 0, cyc = 0, i;
	initial begin rd_r = 0; wr_r = 0; end
	lpr_rx_ctrl uut (.sys_clk(sys_clk), .rst(rst), .clkEn(en), .avs_address(adr), .avs_read(rd_r),
		.avs_write(wr_r), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq), .preambleOk(pre),
		.symValid(sv), .symData(sd), .rssiIn(rssi), .sqiIn(sqi), .serialClockPin(sck), .serialDataPin(sdat),
		.delimIrq(dI), .frameRcvdIrq(fI), .assessDoneIrq(aI), .channelClear(clr), .radioState(st));
	lpr_sym_src src (.sys_clk(sys_clk), .go(go), .byteIn(byteIn), .busy(busy), .symValid(sv), .symData(sd));
	always #2.5 sys_clk = ~sys_clk;
	// sticky event flags, pulse counter, random levels below the threshold, hang guard
	always @(posedge sys_clk) begin
		sawD <= sawD | (dI === 1'b1); sawF <= (sawF | (fI === 1'b1)) & !clrF; sawA <= sawA | (aI === 1'b1);
		pClk <= sck;
		if (sck === 1'b1 && !pClk) begin nClk++; sBits <= {sdat, sBits[7:1]}; end
		rssi <= 8'($random(seed)) & 8'h7f;
		cyc++; if (cyc == 40000) begin mismatches++; report_and_stop(); end
	end
	task report_and_stop();
		if (mismatches == 0 && nChecks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task bus(input logic w, input logic [9:0] ix, input logic [7:0] v);
		adr <= {ix, 2'b00}; wr_r <= w; rd_r <= !w; wd <= {24'h0, v};
		do @(posedge sys_clk); while (wq !== 1'b0);
		rd = rdat[7:0]; wr_r <= 0; rd_r <= 0; @(posedge sys_clk);
	endtask
	task waitSt(input logic [3:0] s);
		for (i = 0; i < 3000 && st !== s; i++) @(posedge sys_clk);
	endtask
	task sendB(input logic [7:0] b);
		go <= 1; byteIn <= b; @(posedge sys_clk); go <= 0;
		do @(posedge sys_clk); while (busy);
	endtask
	// frame check sequence of two bytes, lsb first, generator x^16+x^12+x^5+1
	function automatic logic [15:0] fcs(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] c, w;
		c = 16'h0000;
		w = {b, a};
		for (int j = 0; j < 16; j++) c = (c[0] ^ w[j]) ? ((c >> 1) ^ lpr_pkg::CRC_POLY_REV) : (c >> 1);
		return c;
	endfunction
	// delimiter, length 4, two random bytes, checksum low byte first; bad flips one bit
	task frame(input logic bad);
		logic [15:0] c;
		waitSt(4'h4); sendB(8'h3c); sendB(8'h04);
		for (int k = 0; k < 2; k++) begin d[k] = 8'($random(seed)); sendB(d[k]); end
		c = fcs(d[0], d[1]) ^ {15'h0000, bad};
		sendB(c[7:0]); sendB(c[15:8]);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 0; @(posedge sys_clk);
		bus(0, lpr_pkg::IX_DELIM, 0); `CHK("delim", lpr_pkg::DELIM_RST, rd)
		bus(0, 10'h200, 8'h55); `CHK("unmapped", 8'h00, rd)
		bus(1, lpr_pkg::IX_DLY0, 8'h01); bus(1, lpr_pkg::IX_BASE, 8'h10); bus(1, lpr_pkg::IX_PKTCFG, 8'h01);
		bus(1, lpr_pkg::IX_CMD, lpr_pkg::CMD_RECEIVE); `CHK("cal", 4'h1, st)
		waitSt(4'h3); `CHK("hunt", 4'h3, st)
		en <= 0; pre <= 1; repeat (5) @(posedge sys_clk); `CHK("freeze", 4'h3, st)
		en <= 1; waitSt(4'h4); sendB(8'ha7); `CHK("sfd", 1'b1, sawD)
		sendB(8'h03);
		for (int k = 0; k < 3; k++) begin d[k] = 8'($random(seed)); sendB(d[k]); end
		waitSt(4'h0); `CHK("frame", 1'b1, sawF)
		`CHK("ready", 4'h0, st)
		bus(0, 10'h010, 0); `CHK("len", 8'h03, rd)
		for (int k = 0; k < 3; k++) begin bus(0, 10'(32'h11 + k), 0); `CHK("byte", d[k], rd) end
		// serial mode: eight pulses for one byte, state kept, no frame event
		clrF <= 1; bus(1, lpr_pkg::IX_OPMODE, lpr_pkg::OP_SERIAL); clrF <= 0;
		bus(1, lpr_pkg::IX_DELIM, 8'h3c);
		bus(1, lpr_pkg::IX_CMD, lpr_pkg::CMD_RECEIVE); waitSt(4'h4); sendB(8'h3c);
		nClk = 0; sb = 8'($random(seed)); sendB(sb); `CHK("clocks", 8, nClk)
		`CHK("sdata", sb, sBits)
		`CHK("serial", 4'h7, st)
		`CHK("noframe", 1'b0, sawF)
		bus(1, lpr_pkg::IX_CMD, lpr_pkg::CMD_GO_READY); `CHK("abort", 4'h0, st)
		// single assessment over the compatible window against a mid threshold
		pre <= 0; bus(1, lpr_pkg::IX_AVG, 8'h02); bus(1, lpr_pkg::IX_THR, 8'h80);
		bus(1, lpr_pkg::IX_CMD, lpr_pkg::CMD_ASSESS);
		for (i = 0; i < 16000 && !sawA; i++) @(posedge sys_clk);
		`CHK("done", 1'b1, sawA)
		@(posedge sys_clk); `CHK("clear", 1'b1, clr)
		`CHK("end", 4'h0, st)
		bus(0, lpr_pkg::IX_RSSI, 0); `CHK("avg", 1'b1, rd > 8'h20 && rd < 8'h60)
		// checksum on: a corrupt frame is dropped, a good one keeps quality in its last byte
		bus(1, lpr_pkg::IX_OPMODE, lpr_pkg::OP_PACKET); bus(1, lpr_pkg::IX_PKTCFG, 8'h00);
		bus(1, lpr_pkg::IX_CMD, lpr_pkg::CMD_RECEIVE); pre <= 1;
		frame(1'b1); `CHK("badfcs", 1'b0, sawF)
		frame(1'b0); waitSt(4'h0); `CHK("goodfcs", 1'b1, sawF)
		bus(0, 10'h014, 0); `CHK("sqi", 8'h5a, rd)
		report_and_stop();
	end
endmodule
`default_nettype wire
